// file: inc/frame_seq_pkg.sv
package frame_seq_pkg;
  // ****************************************
  // Register indices; byte address is four times the index
  // ****************************************
  localparam logic [7:0]  RSVD_A_IDX      = 8'hCF;
  localparam logic [7:0]  RSVD_B_IDX      = 8'hD0;
  localparam logic [7:0]  FRAME_COUNT_IDX = 8'hD1;
  localparam logic [7:0]  WORD_PTR_IDX    = 8'hD2;
  localparam logic [7:0]  CONFIG_IDX      = 8'hD3;
  localparam logic [7:0]  FRAME_DATA_IDX  = 8'hD4;
  localparam logic [7:0]  STATUS_IDX      = 8'hD5;
  localparam int          ADDR_W          = 12;

  // ****************************************
  // Field layout and reset values
  // ****************************************
  localparam int          MODE_LSB        = 0;
  localparam int          MODE_MSB        = 1;
  localparam int          AUTO_RESTART_B  = 3;
  localparam logic [15:0] CONFIG_WR_MASK  = 16'hF00B;
  localparam logic [1:0]  MODE_IDLE       = 2'h0;
  localparam logic [1:0]  MODE_FRAME_LOAD = 2'h1;
  localparam logic [1:0]  MODE_RUN        = 2'h2;
  localparam logic [7:0]  FRAME_COUNT_MIN = 8'h01;
  localparam logic [7:0]  FRAME_COUNT_MAX = 8'h80;
  localparam logic [7:0]  FRAME_COUNT_RST = 8'h01;
  localparam logic [7:0]  WORD_PTR_MAX    = 8'hFF;
  localparam logic [7:0]  WORD_PTR_RST    = 8'h00;
  localparam logic [15:0] CONFIG_RST      = 16'h0000;
  localparam int          MEM_DEPTH       = 256;
  localparam int          STAT_RUNNING_B  = 0;
  localparam int          STAT_DONE_B     = 1;
  localparam int          STAT_FRAME_LSB  = 8;

  typedef enum logic [2:0] {
    SEQ_IDLE  = 3'b001,
    SEQ_FETCH = 3'b010,
    SEQ_COUNT = 3'b100
  } seq_state_t;
endpackage : frame_seq_pkg

// file: rtl/frame_sequencer_params.sv
// Notes on behaviour
// R1: Frame count selects how many frames run; legal values one to 128.
// R2: Host writes frame count before selecting frame-load mode.
// R3: Running starts at frame 0, advances in order, ends at count minus one.
// R4: After the last frame, frame 0 reloads; halt or repeat per auto-restart.
// R5: Word pointer selects the frame data location; legal values zero to 255.
// R6: Pointer advances on each frame data access, reaching consecutive locations.
// R7: Host writes zero to configuration bits 2 and 4 through 11.
// R8: Pointer steps by exactly one per data word access, stopping at 255.
module frame_sequencer_params
  import frame_seq_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   seqRunning,
  output logic      [6:0]        frameIndex,
  output logic      [15:0]       frameTarget,
  output logic                   frameStrobe
);

  // ****************************************
  // Bus decode
  // ****************************************
  logic [7:0]  regIdx;
  logic        addrOk;
  logic        setup;
  logic        access;
  logic        wrAcc;
  logic        rdAcc;
  logic        mapped;
  logic [15:0] wdata;

  assign regIdx = paddr[9:2];
  assign addrOk = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:10] == '0);
  assign setup  = psel && !penable && !pready;
  assign access = psel && penable && pready;
  assign wrAcc  = access && pwrite;
  assign rdAcc  = access && !pwrite;
  assign wdata  = pwdata[15:0];

  always_comb begin
    mapped = 1'b0;
    if (addrOk) begin
      unique case (regIdx)
        RSVD_A_IDX, RSVD_B_IDX, FRAME_COUNT_IDX, WORD_PTR_IDX,
        CONFIG_IDX, FRAME_DATA_IDX, STATUS_IDX: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0]  frameCount_q;
  logic [7:0]  wordPtr_q;
  logic [15:0] config_q;
  logic        done_q;
  logic [15:0] frameMem [MEM_DEPTH];
  seq_state_t  state_q;
  logic [6:0]  frame_q;
  logic [15:0] ticks_q;

  logic        wrCount;
  logic        wrPtr;
  logic        wrCfg;
  logic        dataAcc;
  logic [1:0]  mode;
  logic        autoRestart;
  logic        startReq;
  logic        lastFrame;
  logic        finish;

  assign wrCount     = wrAcc && mapped && regIdx == FRAME_COUNT_IDX;
  assign wrPtr       = wrAcc && mapped && regIdx == WORD_PTR_IDX;
  assign wrCfg       = wrAcc && mapped && regIdx == CONFIG_IDX;
  assign dataAcc     = access && mapped && regIdx == FRAME_DATA_IDX;
  assign mode        = config_q[MODE_MSB:MODE_LSB];
  assign autoRestart = config_q[AUTO_RESTART_B];
  assign startReq    = wrCfg && wdata[MODE_MSB:MODE_LSB] == MODE_RUN;

  // Out-of-range counts are clamped so the sequencer never runs zero frames
  always_ff @(posedge core_clk) begin
    if (reset) begin
      frameCount_q <= FRAME_COUNT_RST;
    end else if (wrCount) begin
      if (wdata == 16'h0000) begin
        frameCount_q <= FRAME_COUNT_MIN; // R1
      end else if (wdata > {8'h00, FRAME_COUNT_MAX}) begin
        frameCount_q <= FRAME_COUNT_MAX; // R1
      end else begin
        frameCount_q <= wdata[7:0]; // R1
      end
    end
  end

  // A direct pointer write takes precedence over the access that steps it
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wordPtr_q <= WORD_PTR_RST;
    end else if (wrPtr) begin
      wordPtr_q <= wdata[7:0]; // R5
    end else if (dataAcc && wordPtr_q != WORD_PTR_MAX) begin
      wordPtr_q <= wordPtr_q + 8'h01; // R6 R8
    end
  end

  // Reserved bits are not stored, so they always read back as zero
  always_ff @(posedge core_clk) begin
    if (reset) begin
      config_q <= CONFIG_RST;
    end else if (wrCfg) begin
      config_q <= wdata & CONFIG_WR_MASK; // R7
    end
  end

  // Frame words only change in load mode, so a running sequence is never torn
  always_ff @(posedge core_clk) begin
    if (dataAcc && pwrite && mode == MODE_FRAME_LOAD) begin
      frameMem[wordPtr_q] <= wdata; // R2
    end
  end

  // Completion flag: a finish in the same cycle as a config write wins
  always_ff @(posedge core_clk) begin
    if (reset) begin
      done_q <= 1'b0;
    end else if (finish) begin
      done_q <= 1'b1;
    end else if (wrCfg) begin
      done_q <= 1'b0;
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  // Each frame is two words: target, then duration in clock ticks
  logic [7:0] tgtAddr;
  logic [7:0] durAddr;

  assign tgtAddr   = {frame_q, 1'b0};
  assign durAddr   = {frame_q, 1'b1};
  assign lastFrame = {1'b0, frame_q} == frameCount_q - 8'h01;
  assign finish    = state_q == SEQ_COUNT && ticks_q <= 16'h0001 && lastFrame
                     && !autoRestart && mode == MODE_RUN;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_q     <= SEQ_IDLE;
      frame_q     <= 7'h00;
      ticks_q     <= 16'h0000;
      frameTarget <= 16'h0000;
      frameStrobe <= 1'b0;
    end else begin
      frameStrobe <= 1'b0;
      unique case (state_q)
        SEQ_IDLE: begin
          if (startReq) begin
            frame_q <= 7'h00; // R3
            state_q <= SEQ_FETCH;
          end
        end
        SEQ_FETCH: begin
          if (mode != MODE_RUN) begin
            state_q <= SEQ_IDLE;
          end else begin
            frameTarget <= frameMem[tgtAddr];
            ticks_q     <= frameMem[durAddr];
            frameStrobe <= 1'b1;
            state_q     <= SEQ_COUNT;
          end
        end
        SEQ_COUNT: begin
          if (mode != MODE_RUN) begin
            state_q <= SEQ_IDLE;
          end else if (ticks_q > 16'h0001) begin
            ticks_q <= ticks_q - 16'h0001;
          end else if (!lastFrame) begin
            frame_q <= frame_q + 7'h01; // R3
            state_q <= SEQ_FETCH;
          end else if (autoRestart) begin
            frame_q <= 7'h00; // R4
            state_q <= SEQ_FETCH;
          end else begin
            // Halting still presents frame 0 so the next start is seamless
            frame_q     <= 7'h00; // R4
            frameTarget <= frameMem[8'h00]; // R4
            frameStrobe <= 1'b1;
            state_q     <= SEQ_IDLE;
          end
        end
        default: state_q <= SEQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      seqRunning <= 1'b0;
      frameIndex <= 7'h00;
    end else begin
      seqRunning <= state_q != SEQ_IDLE;
      frameIndex <= frame_q;
    end
  end

  // ****************************************
  // Bus answer
  // ****************************************
  // No wait state: read data is captured in setup, answered in the first access cycle
  logic [15:0] rdVal;

  always_comb begin
    rdVal = 16'h0000;
    if (addrOk) begin
      unique case (regIdx)
        FRAME_COUNT_IDX: rdVal = {8'h00, frameCount_q};
        WORD_PTR_IDX:    rdVal = {8'h00, wordPtr_q};
        CONFIG_IDX:      rdVal = config_q;
        FRAME_DATA_IDX:  rdVal = frameMem[wordPtr_q];
        STATUS_IDX:      rdVal = {1'b0, frame_q, 6'h00, done_q, state_q != SEQ_IDLE};
        default:         rdVal = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      if (setup && !pwrite) begin
        prdata <= {16'h0000, rdVal};
      end else if (rdAcc) begin
        prdata <= 32'h0000_0000;
      end
    end
  end

endmodule : frame_sequencer_params

// file: tb/frame_seq_props.sv
module frame_seq_props
  import frame_seq_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        seqRunning,
  input wire logic [6:0]  frameIndex
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  property p_ans; psel && !penable |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("no answer after setup");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("pready held too long");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without pready");
  property p_hi; pready |-> prdata[31:16] == 16'h0000; endproperty
  a_hi: assert property (p_hi) else $error("upper read data set");
  property p_start; $rose(seqRunning) |-> frameIndex == 7'h00; endproperty
  a_start: assert property (p_start) else $error("run not at frame 0");
  property p_step;
    $changed(frameIndex) |-> frameIndex == 7'h00 || frameIndex == $past(frameIndex) + 7'h01;
  endproperty
  a_step: assert property (p_step) else $error("frame index skipped");
  property p_reload; $fell(seqRunning) |-> frameIndex == 7'h00; endproperty
  a_reload: assert property (p_reload) else $error("halt without frame 0");
endmodule : frame_seq_props

bind frame_sequencer_params frame_seq_props i_frame_seq_props (
  .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .seqRunning(seqRunning), .frameIndex(frameIndex));

// file: tb/param_host.sv
module param_host
  import frame_seq_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic [31:0]       prdata,
  input  wire logic              pready,
  input  wire logic              pslverr,
  output logic                   psel,
  output logic                   penable,
  output logic                   pwrite,
  output logic      [ADDR_W-1:0] paddr,
  output logic      [31:0]       pwdata
);
  timeunit 1ns;
  timeprecision 1ns;
  int stalls = 0;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
  end
  // Request held until pready is sampled; a stuck slave is counted, not waited on forever
  task xfer(input logic w, input logic [7:0] i, input logic [15:0] d,
            output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, i, 2'h0};
    pwdata <= {16'h0000, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) stalls++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : param_host

// file: tb/frame_sequencer_params_tb.sv
module frame_sequencer_params_tb
  import frame_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic              core_clk = 1'b0;
  logic              reset = 1'b1;
  logic              psel, penable, pwrite, pready, pslverr, seqRunning, frameStrobe, er;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic [6:0]        frameIndex;
  logic [15:0]       frameTarget;
  logic [15:0]       words [4] = '{16'hA0A0, 16'h0003, 16'hB0B0, 16'h0002};
  int                err_count = 0;
  int                n_compared = 0;
  always #50 core_clk = ~core_clk;
  frame_sequencer_params i_frame_sequencer_params (.core_clk(core_clk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .seqRunning(seqRunning),
    .frameIndex(frameIndex), .frameTarget(frameTarget), .frameStrobe(frameStrobe));
  param_host i_param_host (.core_clk(core_clk), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata));
  task give_verdict;
    err_count += i_param_host.stalls;
    $display("Compared %0d, errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
    if (i_param_host.stalls != 0) give_verdict();
  endtask : cmp
  task wr(input logic [7:0] i, input logic [15:0] d);
    i_param_host.xfer(1'b1, i, d, rd, er);
  endtask : wr
  task rdc(input logic [7:0] i, input logic [31:0] e);
    i_param_host.xfer(1'b0, i, 16'h0000, rd, er);
    cmp(rd, e);
  endtask : rdc
  task strb(input logic [15:0] e);
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (frameStrobe !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_count++;
      give_verdict();
    end
    cmp({16'h0000, frameTarget}, {16'h0000, e});
  endtask : strb
  initial begin
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    rdc(FRAME_COUNT_IDX, 32'h1);
    rdc(WORD_PTR_IDX, 32'h0);
    wr(FRAME_COUNT_IDX, 16'h0000);
    rdc(FRAME_COUNT_IDX, 32'h1);
    wr(FRAME_COUNT_IDX, 16'h00C8);
    rdc(FRAME_COUNT_IDX, 32'h80);
    wr(FRAME_COUNT_IDX, 16'h0002);
    wr(CONFIG_IDX, 16'h0001);
    wr(WORD_PTR_IDX, 16'h0000);
    foreach (words[k]) wr(FRAME_DATA_IDX, words[k]);
    rdc(WORD_PTR_IDX, 32'h4);
    wr(WORD_PTR_IDX, 16'h0000);
    foreach (words[k]) rdc(FRAME_DATA_IDX, {16'h0000, words[k]});
    wr(WORD_PTR_IDX, 16'h00FE);
    repeat (3) i_param_host.xfer(1'b0, FRAME_DATA_IDX, 16'h0000, rd, er);
    rdc(WORD_PTR_IDX, 32'hFF);
    wr(CONFIG_IDX, 16'h0002);
    strb(16'hA0A0);
    strb(16'hB0B0);
    strb(16'hA0A0);
    rdc(STATUS_IDX, 32'h2);
    cmp({31'h0, seqRunning}, 32'h0);
    cmp({25'h0, frameIndex}, 32'h0);
    wr(CONFIG_IDX, 16'h000A);
    for (int k = 0; k < 4; k++) begin
      strb(words[(k % 2) * 2]);
      cmp({25'h0, frameIndex}, 32'(k % 2));
      cmp({31'h0, seqRunning}, 32'h1);
    end
    wr(CONFIG_IDX, 16'h0000);
    wr(WORD_PTR_IDX, 16'h0000);
    wr(FRAME_DATA_IDX, 16'h1234);
    rdc(WORD_PTR_IDX, 32'h1);
    wr(WORD_PTR_IDX, 16'h0000);
    rdc(FRAME_DATA_IDX, 32'hA0A0);
    rdc(8'h10, 32'h0);
    cmp({31'h0, er}, 32'h1);
    wr(RSVD_B_IDX, 16'hFFFF);
    rdc(RSVD_B_IDX, 32'h0);
    cmp({31'h0, er}, 32'h0);
    give_verdict();
  end
endmodule : frame_sequencer_params_tb
